// [verif/tmw_tb_top.sv]
// self-checking bench for the waveform timer: registers, pins, count modes, irq
`timescale 1ns/100ps
`default_nettype none
module timer16_waveform_mode_control_tb_top
    import tmw_pkg::*;
;
    logic clk, reset, psel, penable, pwrite, timer_tick, capture_input_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, irq, err;
    int n_mismatch = 0;
    int n_checks = 0;

    tmw_waveform_timer u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .capture_input_pin(capture_input_pin), .pin_a_out(pin_a_out),
        .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .irq(irq));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // word and bit comparisons
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(what, exp, rd);
    endtask

    // load the counter, then n ticks; each tick leaves time for flags and pins to settle
    task automatic run(input logic [15:0] cnt, input int n);
        wr(TMW_OFS_COUNT, {16'h0000, cnt});
        repeat (n) begin
            @(posedge clk);
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    // ctrl_a reset value, writable bits, unmapped address
    task automatic t_regs();
        rdchk("ctrl_a reset", TMW_OFS_CTRL_A, 32'h0000_0000);
        wr(TMW_OFS_CTRL_A, 32'h0000_00FF);
        rdchk("ctrl_a bits", TMW_OFS_CTRL_A, {24'h00_0000, TMW_CTRL_A_WMASK});
        wr(TMW_OFS_CTRL_B, 32'h0000_00FF);
        rdchk("ctrl_b bits", TMW_OFS_CTRL_B, {24'h00_0000, TMW_CTRL_B_WMASK});
        wr(TMW_OFS_CTRL_A, 32'h0000_0000);
        wr(TMW_OFS_CTRL_B, 32'h0000_0000);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk_bit("unmapped slverr", 1'b1, err);
        chk_word("unmapped rdata", 32'h0000_0000, rd);
        $display("regs done");
    endtask

    // mode 0: port fallback, driver gating, set/clear/toggle, irq mask and clear
    task automatic t_nonpwm();
        logic [1:0] md [3] = '{2'b11, 2'b10, 2'b01};
        logic ex [3] = '{1'b1, 1'b0, 1'b1};
        wr(TMW_OFS_PIN_CTRL, 32'h0000_0009);
        wr(TMW_OFS_CMP_A, 32'h0000_0010);
        wr(TMW_OFS_CMP_B, 32'h0000_0010);
        repeat (2) @(posedge clk);
        chk_bit("a port", 1'b0, pin_a_out);
        chk_bit("b port", 1'b1, pin_b_out);
        for (int k = 0; k < 3; k++) begin
            wr(TMW_OFS_CTRL_A, {24'h00_0000, md[k], md[k], 4'b0000});
            run(16'h000F, 2);
            chk_bit("a match", ex[k], pin_a_out);
            chk_bit("b match", ex[k], pin_b_out);
            chk_bit("a oe", 1'b1, pin_a_oe);
            chk_bit("b oe", 1'b0, pin_b_oe);
        end
        chk_bit("irq masked", 1'b0, irq);
        wr(TMW_OFS_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk_bit("irq on", 1'b1, irq);
        rdchk("status", TMW_OFS_IRQ_STATUS, 32'h0000_0006);
        repeat (2) @(posedge clk);
        chk_bit("irq off", 1'b0, irq);
        rdchk("status clr", TMW_OFS_IRQ_STATUS, 32'h0000_0000);
        wr(TMW_OFS_IRQ_MASK, 32'h0000_0000);
        $display("nonpwm done");
    endtask

    // fast modes 5 and 15: clear on match, set at top, wrap, toggle gating
    task automatic t_fast();
        wr(TMW_OFS_CTRL_B, 32'h0000_0008);
        wr(TMW_OFS_CTRL_A, 32'h0000_0081);
        run(16'h000F, 2);
        chk_bit("fast clear", 1'b0, pin_a_out);
        run(16'h00FE, 2);
        chk_bit("fast set top", 1'b1, pin_a_out);
        rdchk("fast wrap", TMW_OFS_COUNT, {16'h0000, TMW_BOTTOM});
        rdchk("fast flags", TMW_OFS_IRQ_STATUS, 32'h0000_0007);
        wr(TMW_OFS_CTRL_A, 32'h0000_0041);
        run(16'h000F, 2);
        chk_bit("mode5 no toggle", 1'b1, pin_a_out);
        wr(TMW_OFS_CTRL_B, 32'h0000_0018);
        wr(TMW_OFS_CTRL_A, 32'h0000_0043);
        run(16'h000F, 2);
        chk_bit("mode15 toggle", 1'b0, pin_a_out);
        $display("fast done");
    endtask

    // phase correct mode 1: turn at top, turn at bottom, up/down matches
    task automatic t_phase();
        wr(TMW_OFS_CTRL_B, 32'h0000_0000);
        wr(TMW_OFS_CTRL_A, 32'h0000_0081);
        wr(TMW_OFS_CMP_A, 32'h0000_0080);
        wr(TMW_OFS_CMP_B, 32'h0000_0300);
        apb(1'b0, TMW_OFS_IRQ_STATUS, 32'h0000_0000);
        run(16'h00FD, 3);
        rdchk("turn at top", TMW_OFS_COUNT, 32'h0000_00FE);
        run(16'h0081, 2);
        chk_bit("down match", 1'b1, pin_a_out);
        run(16'h0002, 3);
        rdchk("turn at bottom", TMW_OFS_COUNT, 32'h0000_0001);
        run(16'h007F, 2);
        chk_bit("up match", 1'b0, pin_a_out);
        rdchk("ovf bottom", TMW_OFS_IRQ_STATUS, 32'h0000_0003);
        $display("phase done");
    endtask

    // capture pin ignored in mode 12, taken in mode 0
    task automatic t_capture();
        logic [31:0] cb [2] = '{32'h0000_0018, 32'h0000_0000};
        wr(TMW_OFS_CTRL_A, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            wr(TMW_OFS_CTRL_B, cb[k]);
            apb(1'b0, TMW_OFS_IRQ_STATUS, 32'h0000_0000);
            capture_input_pin <= 1'b1;
            run(16'h0000, 1);
            capture_input_pin <= 1'b0;
            run(16'h0000, 1);
            apb(1'b0, TMW_OFS_IRQ_STATUS, 32'h0000_0000);
            chk_bit("capture flag", k[0], rd[TMW_ST_CAPT]);
        end
        $display("capture done");
    endtask

    // phase and frequency correct mode 9: a new top takes effect only after bottom
    task automatic t_pfc();
        wr(TMW_OFS_CTRL_A, 32'h0000_00C1);
        wr(TMW_OFS_CTRL_B, 32'h0000_0010);
        wr(TMW_OFS_CMP_A, 32'h0000_0040);
        apb(1'b0, TMW_OFS_IRQ_STATUS, 32'h0000_0000);
        run(16'h007F, 2);
        rdchk("pfc old top", TMW_OFS_COUNT, 32'h0000_007F);
        chk_bit("pfc up match", 1'b1, pin_a_out);
        run(16'h0001, 2);
        rdchk("pfc bottom turn", TMW_OFS_COUNT, 32'h0000_0001);
        run(16'h003F, 2);
        rdchk("pfc new top", TMW_OFS_COUNT, 32'h0000_003F);
        rdchk("pfc flags", TMW_OFS_IRQ_STATUS, 32'h0000_0003);
        $display("pfc done");
    endtask

    // reset, scenarios, verdict
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        timer_tick = 1'b0;
        capture_input_pin = 1'b0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_nonpwm();
        t_fast();
        t_phase();
        t_capture();
        t_pfc();
        report_and_stop();
    end
endmodule // timer16_waveform_mode_control_tb_top
`default_nettype wire

// [verilog/tmw_pkg.sv]
// constants for the timer waveform mode and compare output block
package tmw_pkg;
    // register byte offsets
    localparam logic [7:0] TMW_OFS_CTRL_A = 8'h00;
    localparam logic [7:0] TMW_OFS_CTRL_B = 8'h04;
    localparam logic [7:0] TMW_OFS_COUNT = 8'h08;
    localparam logic [7:0] TMW_OFS_CMP_A = 8'h0C;
    localparam logic [7:0] TMW_OFS_CMP_B = 8'h10;
    localparam logic [7:0] TMW_OFS_CAPTURE = 8'h14;
    localparam logic [7:0] TMW_OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] TMW_OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] TMW_OFS_PIN_CTRL = 8'h20;
    // write masks and reset values
    localparam logic [7:0] TMW_CTRL_A_WMASK = 8'hF3;
    localparam logic [7:0] TMW_CTRL_B_WMASK = 8'hDF;
    localparam logic [7:0] TMW_CTRL_RESET = 8'h00;
    localparam logic [15:0] TMW_WORD_RESET = 16'h0000;
    // field positions
    localparam int TMW_WGM_HI_POS = 3;
    localparam int TMW_COM_A_POS = 6;
    localparam int TMW_COM_B_POS = 4;
    // status bits
    localparam int TMW_ST_OVF = 0;
    localparam int TMW_ST_CMP_A = 1;
    localparam int TMW_ST_CMP_B = 2;
    localparam int TMW_ST_CAPT = 3;
    // count limits
    localparam logic [15:0] TMW_BOTTOM = 16'h0000;
    localparam logic [15:0] TMW_MAX = 16'hFFFF;
    localparam logic [15:0] TMW_TOP_8 = 16'h00FF;
    localparam logic [15:0] TMW_TOP_9 = 16'h01FF;
    localparam logic [15:0] TMW_TOP_10 = 16'h03FF;
    // waveform kinds
    typedef enum logic [1:0] {TMW_NONPWM, TMW_FAST, TMW_PHASE, TMW_PFC} tmw_kind_t;
endpackage

// [verilog/tmw_waveform_timer.sv]
// 16-bit timer waveform mode decode, counter and compare outputs with apb registers
// Functional notes
// - all logic on clk; timer_tick only enables counting, match and overflow flags and compare loads
// - phase and frequency correct modes load compare values at bottom
// - bottom overflow uses same tick timing as top overflow
// - nonzero output mode field hands the pin to the compare output
// - pin driver enabled only when its direction bit selects output
// - non-pwm: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm 01 toggles a only in modes 14, 15
// - fast pwm 10 clear on match set at top, 11 reverse
// - fast pwm match at top ignored when mode msb set
// - dual slope 01 toggles a only in modes 8 to 11
// - dual slope 10 clear up-match set down-match, 11 reverse
// - four-bit waveform mode from control a low and control b bits
// - modes 0, 4, 12: top ffff, compare a, capture; immediate; max overflow
// - fast modes 5-7 fixed tops, 14, 15 capture, compare a
// - phase correct 1-3 fixed tops, 10, 11 variable; overflow at bottom
// - modes 8, 9 top capture or compare a; update and overflow at bottom
// - dual slope counts up to top, steps to top-1 on the next tick, counts down
// - capture pin ignored while capture register is top
`timescale 1ns/100ps
`default_nettype none
module tmw_waveform_timer
    import tmw_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_tick,
    input wire logic capture_input_pin,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] cnt;
        logic down;
        logic [15:0] ocr_a;
        logic [15:0] ocr_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] icr;
        logic cap_q;
        logic oc_a;
        logic oc_b;
        logic [3:0] status;
        logic [3:0] mask;
        logic [3:0] pin_ctrl;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
        logic pa_out;
        logic pa_oe;
        logic pb_out;
        logic pb_oe;
    } tmw_state_t;

    tmw_state_t st_r;
    tmw_state_t st_nxt;

    // kind of waveform for a mode, reserved mode as normal
    function automatic tmw_kind_t mode_kind(input logic [3:0] m);
        unique case (m)
            4'd1, 4'd2, 4'd3, 4'd10, 4'd11: mode_kind = TMW_PHASE;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15: mode_kind = TMW_FAST;
            4'd8, 4'd9: mode_kind = TMW_PFC;
            default: mode_kind = TMW_NONPWM;
        endcase
    endfunction

    // top value for a mode
    function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] oa, input logic [15:0] ic);
        unique case (m)
            4'd1, 4'd5: mode_top = TMW_TOP_8;
            4'd2, 4'd6: mode_top = TMW_TOP_9;
            4'd3, 4'd7: mode_top = TMW_TOP_10;
            4'd4, 4'd9, 4'd11, 4'd15: mode_top = oa;
            4'd8, 4'd10, 4'd12, 4'd14: mode_top = ic;
            default: mode_top = TMW_MAX;
        endcase
    endfunction

    // pin output for a channel: override picks the compare output
    function automatic logic [1:0] pin_drive(input logic [1:0] com, input logic oc, input logic dir,
                                             input logic val);
        pin_drive = {(|com) ? oc : val, dir};
    endfunction

    logic [3:0] wgm;
    tmw_kind_t kind;
    logic [15:0] top;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic at_top;
    logic at_bot;
    logic match_a;
    logic match_b;
    logic toggle_ok;
    logic upd;
    logic ovf;
    logic icr_top;
    logic wr;
    logic rd;
    logic hit;
    logic [1:0] pa;
    logic [1:0] pb;

    // mode decode
    always_comb begin
        wgm = {st_r.ctrl_b[TMW_WGM_HI_POS+1:TMW_WGM_HI_POS], st_r.ctrl_a[1:0]};
        kind = mode_kind(wgm);
        top = mode_top(wgm, st_r.ocr_a, st_r.icr);
        com_a = st_r.ctrl_a[TMW_COM_A_POS+1:TMW_COM_A_POS];
        com_b = st_r.ctrl_a[TMW_COM_B_POS+1:TMW_COM_B_POS];
        at_top = st_r.cnt == top;
        at_bot = st_r.cnt == TMW_BOTTOM;
        icr_top = wgm == 4'd8 || wgm == 4'd10 || wgm == 4'd12 || wgm == 4'd14;
        toggle_ok = (kind == TMW_FAST && wgm[3:1] == 3'b111) || (kind != TMW_FAST && wgm[3:2] == 2'b10);
        // update and overflow points, all qualified by the tick
        unique case (kind)
            TMW_NONPWM: begin
                upd = 1'b0;
                ovf = timer_tick && st_r.cnt == TMW_MAX;
            end
            TMW_FAST: begin
                upd = timer_tick && at_top;
                ovf = timer_tick && at_top;
            end
            TMW_PHASE: begin
                upd = timer_tick && at_top;
                ovf = timer_tick && at_bot;
            end
            TMW_PFC: begin
                upd = timer_tick && at_bot;
                ovf = timer_tick && at_bot;
            end
        endcase
        match_a = timer_tick && st_r.cnt == st_r.ocr_a && !(kind == TMW_FAST && at_top && com_a[1]);
        match_b = timer_tick && st_r.cnt == st_r.ocr_b && !(kind == TMW_FAST && at_top && com_b[1]);
        wr = psel && penable && pwrite && st_r.ready;
        rd = psel && penable && !pwrite && st_r.ready;
        hit = paddr <= TMW_OFS_PIN_CTRL && paddr[1:0] == 2'b00;
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        // counter sequence on the tick only
        if (timer_tick) begin
            if (kind == TMW_PHASE || kind == TMW_PFC) begin
                if (!st_r.down && at_top) begin
                    st_nxt.down = 1'b1;
                    st_nxt.cnt = st_r.cnt - 16'h0001;
                end else if (st_r.down && at_bot) begin
                    st_nxt.down = 1'b0;
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end else begin
                    st_nxt.cnt = st_r.down ? st_r.cnt - 16'h0001 : st_r.cnt + 16'h0001;
                end
            end else begin
                st_nxt.down = 1'b0;
                st_nxt.cnt = (at_top && wgm != 4'd0) ? TMW_BOTTOM : st_r.cnt + 16'h0001;
            end
        end
        // buffered compare values reach the comparators at the update point
        if (upd) begin
            st_nxt.ocr_a = st_r.buf_a;
            st_nxt.ocr_b = st_r.buf_b;
        end
        // channel a output
        if (kind == TMW_NONPWM) begin
            if (match_a) begin
                unique case (com_a)
                    2'b01: st_nxt.oc_a = !st_r.oc_a;
                    2'b10: st_nxt.oc_a = 1'b0;
                    2'b11: st_nxt.oc_a = 1'b1;
                    default: st_nxt.oc_a = st_r.oc_a;
                endcase
            end
        end else if (kind == TMW_FAST) begin
            if (match_a && com_a == 2'b01 && toggle_ok) begin
                st_nxt.oc_a = !st_r.oc_a;
            end else if (match_a && com_a[1]) begin
                st_nxt.oc_a = com_a[0];
            end else if (timer_tick && at_top && com_a[1]) begin
                st_nxt.oc_a = !com_a[0];
            end
        end else if (match_a) begin
            if (com_a == 2'b01 && toggle_ok) begin
                st_nxt.oc_a = !st_r.oc_a;
            end else if (com_a[1]) begin
                st_nxt.oc_a = com_a[0] ^ st_r.down;
            end
        end
        // channel b output, no toggle outside non-pwm modes
        if (kind == TMW_NONPWM) begin
            if (match_b) begin
                unique case (com_b)
                    2'b01: st_nxt.oc_b = !st_r.oc_b;
                    2'b10: st_nxt.oc_b = 1'b0;
                    2'b11: st_nxt.oc_b = 1'b1;
                    default: st_nxt.oc_b = st_r.oc_b;
                endcase
            end
        end else if (kind == TMW_FAST) begin
            if (match_b && com_b[1]) begin
                st_nxt.oc_b = com_b[0];
            end else if (timer_tick && at_top && com_b[1]) begin
                st_nxt.oc_b = !com_b[0];
            end
        end else if (match_b && com_b[1]) begin
            st_nxt.oc_b = com_b[0] ^ st_r.down;
        end
        // input capture on a rising pin edge
        st_nxt.cap_q = capture_input_pin;
        if (capture_input_pin && !st_r.cap_q && !icr_top) begin
            st_nxt.icr = st_r.cnt;
        end
        // apb handshake: ready one cycle after access starts
        st_nxt.ready = psel && penable && !st_r.ready;
        st_nxt.slverr = psel && penable && !st_r.ready && !hit;
        st_nxt.rdata = 32'h0000_0000;
        if (psel && penable && !st_r.ready && !pwrite) begin
            unique case (paddr)
                TMW_OFS_CTRL_A: st_nxt.rdata[7:0] = st_r.ctrl_a;
                TMW_OFS_CTRL_B: st_nxt.rdata[7:0] = st_r.ctrl_b;
                TMW_OFS_COUNT: st_nxt.rdata[15:0] = st_r.cnt;
                TMW_OFS_CMP_A: st_nxt.rdata[15:0] = st_r.buf_a;
                TMW_OFS_CMP_B: st_nxt.rdata[15:0] = st_r.buf_b;
                TMW_OFS_CAPTURE: st_nxt.rdata[15:0] = st_r.icr;
                TMW_OFS_IRQ_STATUS: st_nxt.rdata[3:0] = st_r.status;
                TMW_OFS_IRQ_MASK: st_nxt.rdata[3:0] = st_r.mask;
                TMW_OFS_PIN_CTRL: st_nxt.rdata[3:0] = st_r.pin_ctrl;
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // register writes
        if (wr) begin
            unique case (paddr)
                TMW_OFS_CTRL_A: st_nxt.ctrl_a = pwdata[7:0] & TMW_CTRL_A_WMASK;
                TMW_OFS_CTRL_B: st_nxt.ctrl_b = pwdata[7:0] & TMW_CTRL_B_WMASK;
                TMW_OFS_COUNT: st_nxt.cnt = pwdata[15:0];
                TMW_OFS_CMP_A: st_nxt.buf_a = pwdata[15:0];
                TMW_OFS_CMP_B: st_nxt.buf_b = pwdata[15:0];
                TMW_OFS_CAPTURE: st_nxt.icr = pwdata[15:0];
                TMW_OFS_IRQ_MASK: st_nxt.mask = pwdata[3:0];
                TMW_OFS_PIN_CTRL: st_nxt.pin_ctrl = pwdata[3:0];
                default: st_nxt.mask = st_r.mask;
            endcase
        end
        // immediate modes pass written compare values straight through
        if (kind == TMW_NONPWM) begin
            st_nxt.ocr_a = st_nxt.buf_a;
            st_nxt.ocr_b = st_nxt.buf_b;
        end
        // sticky status, read clears, a new event wins
        st_nxt.status = ((rd && paddr == TMW_OFS_IRQ_STATUS) ? 4'h0 : st_r.status)
            | {capture_input_pin && !st_r.cap_q && !icr_top, match_b, match_a, ovf};
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
        // pin drivers: pin_ctrl is {value b, value a, dir b, dir a}
        pa = pin_drive(com_a, st_nxt.oc_a, st_nxt.pin_ctrl[0], st_nxt.pin_ctrl[2]);
        pb = pin_drive(com_b, st_nxt.oc_b, st_nxt.pin_ctrl[1], st_nxt.pin_ctrl[3]);
        st_nxt.pa_out = pa[1];
        st_nxt.pa_oe = pa[0];
        st_nxt.pb_out = pb[1];
        st_nxt.pb_oe = pb[0];
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign pin_a_out = st_r.pa_out;
    assign pin_a_oe = st_r.pa_oe;
    assign pin_b_out = st_r.pb_out;
    assign pin_b_oe = st_r.pb_oe;
    assign irq = st_r.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // checks
    tick_gates_count_a: assert property (!timer_tick && !wr |=> st_r.cnt == $past(st_r.cnt))
        else $error("counter moved without tick");
    pfc_bottom_load_a: assert property (kind == TMW_PFC && timer_tick && at_bot |=> st_r.ocr_a == $past(st_r.buf_a))
        else $error("no load at bottom");
    bottom_ovf_a: assert property (kind == TMW_PHASE && timer_tick && at_bot |=> st_r.status[TMW_ST_OVF])
        else $error("overflow missed at bottom");
    pin_dir_a: assert property (st_r.pa_oe == $past(st_nxt.pin_ctrl[0]))
        else $error("driver not tied to direction");
    nonpwm_toggle_a: assert property (kind == TMW_NONPWM && com_a == 2'b01 && match_a |=> st_r.oc_a != $past(st_r.oc_a))
        else $error("no toggle on match");
    fast_top_set_a: assert property (kind == TMW_FAST && timer_tick && at_top && com_a == 2'b10 |=> st_r.oc_a)
        else $error("output not set at top");
    dual_turn_a: assert property (kind == TMW_PHASE && timer_tick && at_top && !st_r.down && !wr |=> st_r.down)
        else $error("no turn at top");
    apb_ready_a: assert property (psel && penable && !st_r.ready |=> st_r.ready ##1 !st_r.ready)
        else $error("ready not one cycle");
    irq_level_a: assert property (st_r.irq == |(st_r.status & st_r.mask))
        else $error("irq level wrong");

    // a nonzero output mode field hands pin a to the compare output
    pin_a_override_a: assert property (|com_a |=> st_r.pa_out == st_r.oc_a)
        else $error("pin a not overridden");

    // a zero output mode field leaves pin a on its port value
    pin_a_port_a: assert property (com_a == 2'b00 |=> st_r.pa_out == st_r.pin_ctrl[2])
        else $error("pin a port value lost");

    // channel b uses its own field for the override
    pin_b_override_a: assert property (|com_b |=> st_r.pb_out == st_r.oc_b)
        else $error("pin b not overridden");

    // pin b driver follows its direction bit only
    pin_b_dir_a: assert property (st_r.pb_oe == st_r.pin_ctrl[1])
        else $error("pin b driver not tied to direction");

    // fast pwm 01 outside modes 14 and 15 leaves output a alone
    fast_no_toggle_a: assert property (kind == TMW_FAST && com_a == 2'b01 && !toggle_ok |=> st_r.oc_a == $past(st_r.oc_a))
        else $error("fast toggle in wrong mode");

    // pwm 01 never moves output b
    pwm_b_quiet_a: assert property (kind != TMW_NONPWM && com_b == 2'b01 |=> st_r.oc_b == $past(st_r.oc_b))
        else $error("output b moved in 01");

    // fast pwm 10 clears on a compare match
    fast_match_clr_a: assert property (kind == TMW_FAST && match_a && com_a == 2'b10 |=> !st_r.oc_a)
        else $error("fast match did not clear");

    // fast pwm match at top with inverting mode: match ignored, cleared at top
    fast_top_ignore_a: assert property (kind == TMW_FAST && timer_tick && at_top && st_r.cnt == st_r.ocr_a
        && com_a == 2'b11 |=> !st_r.oc_a)
        else $error("top match not ignored");

    // dual slope 01 toggles output a in modes 8 to 11
    dual_toggle_a: assert property (kind != TMW_NONPWM && kind != TMW_FAST && match_a && com_a == 2'b01 && toggle_ok
        |=> st_r.oc_a != $past(st_r.oc_a))
        else $error("dual slope toggle missed");

    // dual slope 10 clears on an up-counting match
    dual_up_clr_a: assert property (kind != TMW_NONPWM && kind != TMW_FAST && match_a && com_a == 2'b10 && !st_r.down
        |=> !st_r.oc_a)
        else $error("up match did not clear");

    // dual slope 10 sets on a down-counting match
    dual_down_set_a: assert property (kind != TMW_NONPWM && kind != TMW_FAST && match_a && com_a == 2'b10 && st_r.down
        |=> st_r.oc_a)
        else $error("down match did not set");

    // phase and frequency correct overflow at bottom
    pfc_bottom_ovf_a: assert property (kind == TMW_PFC && timer_tick && at_bot |=> st_r.status[TMW_ST_OVF])
        else $error("pfc overflow missed");

    // fast pwm overflow at top
    fast_top_ovf_a: assert property (kind == TMW_FAST && timer_tick && at_top |=> st_r.status[TMW_ST_OVF])
        else $error("fast overflow missed");

    // normal mode wraps from max to bottom
    normal_wrap_a: assert property (wgm == 4'd0 && timer_tick && st_r.cnt == TMW_MAX && !wr
        |=> st_r.cnt == TMW_BOTTOM)
        else $error("normal mode did not wrap");

    // phase correct 8-bit turns at its fixed top
    phase_fixed_top_a: assert property (wgm == 4'd1 && timer_tick && st_r.cnt == TMW_TOP_8 && !st_r.down && !wr
        |=> st_r.down && st_r.cnt == TMW_TOP_8 - 16'h0001)
        else $error("fixed top turn wrong");

    // capture register holds while it is the top source
    capture_block_a: assert property (icr_top && !wr |=> st_r.icr == $past(st_r.icr))
        else $error("capture taken while top");

    // reserved mode counts like normal mode
    reserved_count_a: assert property (wgm == 4'd13 && timer_tick && !wr
        |=> st_r.cnt == $past(st_r.cnt) + 16'h0001)
        else $error("reserved mode count wrong");
endmodule // tmw_waveform_timer
`default_nettype wire
